// *** include/acacc_pkg.sv ***
/*
  constants and carrier types of the current-channel accumulator,
  comparator, overrange and result-counter configuration block.
  assumes a single 125 MHz clock and results from the converter filter.
*/
// Notes on behaviour
// - bit 7 connects ground switch pin
// - accumulator code 00 disables, holds zero
// - code 01 adds/subtracts, clamped at zero
// - code 10 adds/subtracts, no clamp
// - 32-bit accumulator, wraps on overflow
// - comparator 00 off, 01 flags |I|>=threshold
// - code 10 counts, below threshold clears counter
// - code 11 counts, below threshold decrements
// - bit 2 flags overrange after 125 us
// - bit 0 interrupts when count equals limit
// - only latest voltage/temperature result held
// - counter wraps at limit, clears on mode write
// - unipolar compares 16 bits, signed 15
// - threshold flag when counter equals limit
`default_nettype none
package acacc_pkg;
  // configuration register field positions
  localparam int unsigned CFG_GROUND_SWITCH_PIN_BIT = 7;
  localparam int unsigned CFG_ACC_LSB    = 5;
  localparam int unsigned CFG_CMP_LSB    = 3;
  localparam int unsigned CFG_OVR_BIT    = 2;
  localparam int unsigned CFG_RSVD_BIT   = 1;
  localparam int unsigned CFG_RC_BIT     = 0;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  // reset values of the counters and accumulator
  localparam logic [31:0] ACC_RESET      = 32'h0000_0000;
  localparam logic [7:0]  THV_RESET      = 8'h00;
  localparam logic [15:0] RCV_RESET      = 16'h0000;
  // overrange persistence time
  localparam int unsigned CLK_FREQ_KHZ   = 125000;
  localparam int unsigned OVR_TIME_US    = 125;
  localparam int unsigned OVR_CYCLES     = OVR_TIME_US * CLK_FREQ_KHZ / 1000;
  localparam int unsigned OVR_CNT_W      = 16;

  typedef enum logic [1:0] {
    ACACC_ACC_OFF, ACACC_ACC_CLAMP, ACACC_ACC_SIGNED, ACACC_ACC_UNDEF
  } acacc_acc_mode_t;

  typedef enum logic [1:0] {
    ACACC_CMP_OFF, ACACC_CMP_LEVEL, ACACC_CMP_CNT_RST, ACACC_CMP_CNT_DEC
  } acacc_cmp_mode_t;

  // configuration register layout, msb first
  typedef struct packed {
    logic            ground_switch_pin;
    acacc_acc_mode_t acc_mode;
    acacc_cmp_mode_t cmp_mode;
    logic            ovr_en;
    logic            rsvd;
    logic            rc_en;
  } acacc_cfg_t;

  // one converter result with its strobe
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } acacc_res_t;
endpackage
`default_nettype wire

// *** hw/acacc_top.sv ***
/*
  current-channel extended configuration logic: ground switch, 32-bit
  accumulator, threshold comparator, overrange timer, result counter.
  assumes results arrive as one-cycle strobes synchronous to ref_clk_i
  and that the threshold, limits and overrange level come from outside.
  flag clears are pulses from the status logic; a set in the same cycle
  wins, so no event is lost. mode_wr_i pulses whenever the channel
  control or mode register is written.
  a new configuration applies to results taken from the edge after it.
  a result count limit of zero matches only when the count wraps
  through 16 bits. accumulator code 11 is undefined and holds the total.
  the ground pin changes with the stored bit, on the edge after the write.
*/
`timescale 1ns/10ps
`default_nettype none
module acacc_top #(
  parameter int unsigned OVR_CYCLES = acacc_pkg::OVR_CYCLES
) (
  input  wire logic                ref_clk_i,
  input  wire logic                arst_n_i,
  input  wire logic                cfg_wr_i,
  input  wire logic [7:0]          cfg_wdata_i,
  input  wire logic                mode_wr_i,
  input  wire acacc_pkg::acacc_res_t cur_res_i,
  input  wire acacc_pkg::acacc_res_t vt_res_i,
  input  wire logic                bipolar_i,
  input  wire logic [15:0]         current_threshold_i,
  input  wire logic [7:0]          threshold_count_limit_i,
  input  wire logic [15:0]         result_count_limit_i,
  input  wire logic                ovr_raw_i,
  input  wire logic                thr_flag_clr_i,
  input  wire logic                ovr_flag_clr_i,
  output logic [7:0]               cfg_rdata_o,
  output logic                     ground_switch_pin_o,
  output logic [31:0]              current_accumulator_o,
  output logic [7:0]               threshold_count_value_o,
  output logic [15:0]              result_count_value_o,
  output logic                     thr_flag_o,
  output logic                     ovr_flag_o,
  output logic                     cur_irq_o,
  output logic [15:0]              vt_last_o
);

  acacc_pkg::acacc_cfg_t cfg_q;
  acacc_pkg::acacc_cfg_t cfg_d;
  logic                  gnd_q;
  logic                  gnd_d;

  // configuration register, written whole by software
  // the reserved bit is stored and read back just as it was written
  always_comb begin
    cfg_d = cfg_q;
    if (cfg_wr_i) begin
      cfg_d = acacc_pkg::acacc_cfg_t'(cfg_wdata_i);
    end
    gnd_d = cfg_d.ground_switch_pin;
  end

  // config and pin flops; reset leaves the ground pin disconnected
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_q <= acacc_pkg::acacc_cfg_t'(acacc_pkg::CFG_RESET);
      gnd_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      gnd_q <= gnd_d;
    end
  end

  // magnitude of the current result and threshold compare
  // negating the most negative code gives 0x8000, still above every
  // 15-bit threshold, so full-scale negatives always count.
  // in two's complement mode the top threshold bit is ignored
  logic [15:0] mag;
  logic        neg;
  logic [15:0] thr_eff;
  logic        at_or_above;

  always_comb begin
    neg = bipolar_i & cur_res_i.data[15];
    if (neg) begin
      mag = 16'(~cur_res_i.data + 16'h0001);
    end else begin
      mag = cur_res_i.data;
    end
    if (bipolar_i) begin
      thr_eff = {1'b0, current_threshold_i[14:0]};
    end else begin
      thr_eff = current_threshold_i;
    end
    at_or_above = (mag >= thr_eff);
  end

  // accumulator, updated once per current result
  // off forces zero on every cycle, so a clear needs no result; software
  // still keeps it off for two results before turning it back on.
  // sums are not guarded and wrap at 32 bits after long runs
  logic [31:0] acc_q;
  logic [31:0] acc_d;

  always_comb begin
    acc_d = acc_q;
    case (cfg_q.acc_mode)
      acacc_pkg::ACACC_ACC_OFF: begin
        acc_d = acacc_pkg::ACC_RESET;
      end
      acacc_pkg::ACACC_ACC_CLAMP: begin
        if (cur_res_i.valid) begin
          if (!neg) begin
            acc_d = 32'(acc_q + {16'h0000, mag});
          end else if (acc_q < {16'h0000, mag}) begin
            acc_d = acacc_pkg::ACC_RESET;
          end else begin
            acc_d = 32'(acc_q - {16'h0000, mag});
          end
        end
      end
      acacc_pkg::ACACC_ACC_SIGNED: begin
        if (cur_res_i.valid) begin
          if (!neg) begin
            acc_d = 32'(acc_q + {16'h0000, mag});
          end else begin
            acc_d = 32'(acc_q - {16'h0000, mag});
          end
        end
      end
      default: begin
        acc_d = acc_q; // undefined code holds the total
      end
    endcase
  end

  // accumulator flop
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_q <= acacc_pkg::ACC_RESET;
    end else begin
      acc_q <= acc_d;
    end
  end

  // threshold counter and sticky threshold flag
  // the count saturates at 0xff so a long run above the threshold never
  // wraps round and matches a small limit a second time.
  // a decrement that lands on the limit sets the flag as well
  logic [7:0] thv_q;
  logic [7:0] thv_d;
  logic       thr_q;
  logic       thr_d;
  logic       thr_set;

  always_comb begin
    thv_d   = thv_q;
    thr_set = 1'b0;
    case (cfg_q.cmp_mode)
      acacc_pkg::ACACC_CMP_OFF: begin
        thv_d = thv_q;
      end
      acacc_pkg::ACACC_CMP_LEVEL: begin
        thr_set = cur_res_i.valid & at_or_above;
      end
      acacc_pkg::ACACC_CMP_CNT_RST,
      acacc_pkg::ACACC_CMP_CNT_DEC: begin
        if (cur_res_i.valid) begin
          if (at_or_above) begin
            if (thv_q != 8'hff) begin
              thv_d = 8'(thv_q + 8'h01);
            end
          end else if (cfg_q.cmp_mode == acacc_pkg::ACACC_CMP_CNT_RST) begin
            thv_d = acacc_pkg::THV_RESET;
          end else if (thv_q != 8'h00) begin
            thv_d = 8'(thv_q - 8'h01);
          end
          thr_set = (thv_d == threshold_count_limit_i);
        end
      end
      default: begin
        thv_d = thv_q;
      end
    endcase
    // a set arriving with the clear wins
    thr_d = thr_set | (thr_q & ~thr_flag_clr_i);
  end

  // threshold counter and flag flops
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      thv_q <= acacc_pkg::THV_RESET;
      thr_q <= 1'b0;
    end else begin
      thv_q <= thv_d;
      thr_q <= thr_d;
    end
  end

  // overrange persistence timer and sticky flag
  // the timer stops at its limit and keeps the set asserted while the
  // condition lasts, so a clear during a long overrange is overridden.
  // a single low cycle restarts the count from zero
  logic [acacc_pkg::OVR_CNT_W-1:0] ovr_cnt_q;
  logic [acacc_pkg::OVR_CNT_W-1:0] ovr_cnt_d;
  logic                            ovr_q;
  logic                            ovr_d;
  logic                            ovr_set;
  localparam logic [acacc_pkg::OVR_CNT_W-1:0] OVR_LIM =
    acacc_pkg::OVR_CNT_W'(OVR_CYCLES);

  always_comb begin
    ovr_cnt_d = ovr_cnt_q;
    ovr_set   = 1'b0;
    if (!cfg_q.ovr_en || !ovr_raw_i) begin
      ovr_cnt_d = '0; // a gap restarts the persistence window
    end else if (ovr_cnt_q == OVR_LIM) begin
      ovr_set = 1'b1;
    end else begin
      ovr_cnt_d = acacc_pkg::OVR_CNT_W'(ovr_cnt_q + 1'b1);
    end
    ovr_d = ovr_set | (ovr_q & ~ovr_flag_clr_i);
  end

  // overrange timer and flag flops
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovr_cnt_q <= '0;
      ovr_q     <= 1'b0;
    end else begin
      ovr_cnt_q <= ovr_cnt_d;
      ovr_q     <= ovr_d;
    end
  end

  // result counter and paced current interrupt
  // a mode write in the cycle of a result clears the count and drops
  // that result's interrupt, so counting restarts cleanly
  logic [15:0] rcv_q;
  logic [15:0] rcv_d;
  logic [15:0] rcv_inc;
  logic        irq_q;
  logic        irq_d;

  always_comb begin
    rcv_d   = rcv_q;
    irq_d   = 1'b0;
    rcv_inc = 16'(rcv_q + 16'h0001);
    if (mode_wr_i) begin
      rcv_d = acacc_pkg::RCV_RESET;
    end else if (cur_res_i.valid) begin
      if (!cfg_q.rc_en) begin
        irq_d = 1'b1; // every result interrupts when pacing is off
      end else if (rcv_inc == result_count_limit_i) begin
        rcv_d = acacc_pkg::RCV_RESET;
        irq_d = 1'b1;
      end else begin
        rcv_d = rcv_inc;
      end
    end
  end

  // result counter and interrupt flops
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rcv_q <= acacc_pkg::RCV_RESET;
      irq_q <= 1'b0;
    end else begin
      rcv_q <= rcv_d;
      irq_q <= irq_d;
    end
  end

  // latest voltage/temperature result, older ones overwritten
  logic [15:0] vt_q;
  logic [15:0] vt_d;

  always_comb begin
    vt_d = vt_q;
    if (vt_res_i.valid) begin
      vt_d = vt_res_i.data;
    end
  end

  // latest voltage/temperature result flop
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vt_q <= 16'h0000;
    end else begin
      vt_q <= vt_d;
    end
  end

  // outputs straight from flip-flops
  // nothing is decoded on the way out, so the outputs never glitch
  assign cfg_rdata_o             = cfg_q;
  assign ground_switch_pin_o     = gnd_q;
  assign current_accumulator_o   = acc_q;
  assign threshold_count_value_o = thv_q;
  assign result_count_value_o    = rcv_q;
  assign thr_flag_o              = thr_q;
  assign ovr_flag_o              = ovr_q;
  assign cur_irq_o               = irq_q;
  assign vt_last_o               = vt_q;

endmodule
`default_nettype wire

// *** tb/acacc_props.sv ***
/*
  port checker of the current-channel configuration block.
  assumes it is bound into acacc_top and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module acacc_props #(
  parameter int unsigned OVR_CYCLES = acacc_pkg::OVR_CYCLES
) (
  input wire logic                  ref_clk_i,
  input wire logic                  arst_n_i,
  input wire logic                  cfg_wr_i,
  input wire logic [7:0]            cfg_wdata_i,
  input wire logic                  mode_wr_i,
  input wire acacc_pkg::acacc_res_t cur_res_i,
  input wire logic                  bipolar_i,
  input wire logic [15:0]           current_threshold_i,
  input wire logic                  ovr_raw_i,
  input wire logic [7:0]            cfg_rdata_o,
  input wire logic                  ground_switch_pin_o,
  input wire logic [31:0]           current_accumulator_o,
  input wire logic [7:0]            threshold_count_value_o,
  input wire logic [15:0]           result_count_value_o,
  input wire logic                  thr_flag_o,
  input wire logic                  ovr_flag_o,
  input wire logic                  cur_irq_o
);
  int unsigned run_q;
  int unsigned run_d;
  logic        below;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // length of the current enabled out-of-range run
  always_comb run_d = (cfg_rdata_o[2] && ovr_raw_i) ? run_q + 1 : 0;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) run_q <= 0;
    else run_q <= run_d;
  end
  // unipolar result strictly under the threshold
  assign below = cur_res_i.valid && !bipolar_i &&
                 cur_res_i.data < current_threshold_i;
  AST_GROUND_SWITCH_PIN: assert property (
    cfg_wr_i |=> ground_switch_pin_o == $past(cfg_wdata_i[7]))
    else $error("ground switch differs from written bit");
  AST_ACC_OFF: assert property (
    cfg_rdata_o[6:5] == 2'b00 |=> current_accumulator_o == 32'h0)
    else $error("accumulator not held at zero");
  AST_THR_LEVEL: assert property (
    cur_res_i.valid && !bipolar_i && cfg_rdata_o[4:3] == 2'b01 &&
    cur_res_i.data >= current_threshold_i |=> thr_flag_o)
    else $error("level compare did not set flag");
  AST_THV_CLR: assert property (
    below && cfg_rdata_o[4:3] == 2'b10 |=> threshold_count_value_o == 8'h0)
    else $error("threshold count not cleared");
  AST_THV_DEC: assert property (
    below && cfg_rdata_o[4:3] == 2'b11 && threshold_count_value_o != 8'h0
    |=> threshold_count_value_o == $past(threshold_count_value_o) - 8'h1)
    else $error("threshold count not decremented");
  AST_IRQ_CAUSE: assert property (
    cur_irq_o |-> $past(cur_res_i.valid) && !$past(mode_wr_i))
    else $error("interrupt without result");
  AST_RC_WRAP: assert property (
    $past(cfg_rdata_o[0]) && cur_irq_o |-> result_count_value_o == 16'h0)
    else $error("result count not wrapped at limit");
  AST_RC_CLR: assert property (
    mode_wr_i |=> result_count_value_o == 16'h0)
    else $error("result count not cleared by mode write");
  AST_OVR: assert property (
    $rose(ovr_flag_o) |-> run_q > OVR_CYCLES)
    else $error("overrange flag set too early");
endmodule
bind acacc_top acacc_props #(
  .OVR_CYCLES(OVR_CYCLES)
) u_props (
  .ref_clk_i               (ref_clk_i),
  .arst_n_i                (arst_n_i),
  .cfg_wr_i                (cfg_wr_i),
  .cfg_wdata_i             (cfg_wdata_i),
  .mode_wr_i               (mode_wr_i),
  .cur_res_i               (cur_res_i),
  .bipolar_i               (bipolar_i),
  .current_threshold_i     (current_threshold_i),
  .ovr_raw_i               (ovr_raw_i),
  .cfg_rdata_o             (cfg_rdata_o),
  .ground_switch_pin_o     (ground_switch_pin_o),
  .current_accumulator_o   (current_accumulator_o),
  .threshold_count_value_o (threshold_count_value_o),
  .result_count_value_o    (result_count_value_o),
  .thr_flag_o              (thr_flag_o),
  .ovr_flag_o              (ovr_flag_o),
  .cur_irq_o               (cur_irq_o)
);
`default_nettype wire

// *** tb/test_adc_current_accum_compare_cfg.sv ***
/*
  random self-checking bench of acacc_top with a cycle model.
  assumes the package and acacc_props are compiled beforehand.
*/
`timescale 1ns/10ps
`default_nettype none
module test_adc_current_accum_compare_cfg;
  typedef struct packed {
    logic [7:0]  c;
    logic        g;
    logic [31:0] a;
    logic [7:0]  t;
    logic [15:0] r;
    logic [2:0]  f;
    logic [15:0] v;
  } acacc_note_t;
  localparam int unsigned OVR_CYCLES = 8;
  logic ref_clk_i = 1'b0;
  logic arst_n_i, cfg_wr_i, mode_wr_i, bipolar_i, ovr_raw_i;
  logic thr_flag_clr_i, ovr_flag_clr_i, ground_switch_pin_o;
  logic thr_flag_o, ovr_flag_o, cur_irq_o;
  logic [7:0] cfg_wdata_i, threshold_count_limit_i, cfg_rdata_o;
  logic [7:0] threshold_count_value_o, cfg_m = 8'h00, thv_m = 8'h00;
  logic [15:0] current_threshold_i, result_count_limit_i, vt_last_o;
  logic [15:0] result_count_value_o, rcv_m = 16'h0, vt_m = 16'h0;
  logic [31:0] current_accumulator_o, acc_m = 32'h0;
  logic thr_m = 1'b0, ovr_m = 1'b0, irq_m = 1'b0;
  acacc_pkg::acacc_res_t cur_res_i, vt_res_i;
  acacc_note_t q[$], got, want;
  int run_m = 0, off_res = 0, num_errors = 0, checks_done = 0;
  acacc_top #(
    .OVR_CYCLES(OVR_CYCLES)
  ) uut (
    .ref_clk_i               (ref_clk_i),
    .arst_n_i                (arst_n_i),
    .cfg_wr_i                (cfg_wr_i),
    .cfg_wdata_i             (cfg_wdata_i),
    .mode_wr_i               (mode_wr_i),
    .cur_res_i               (cur_res_i),
    .vt_res_i                (vt_res_i),
    .bipolar_i               (bipolar_i),
    .current_threshold_i     (current_threshold_i),
    .threshold_count_limit_i (threshold_count_limit_i),
    .result_count_limit_i    (result_count_limit_i),
    .ovr_raw_i               (ovr_raw_i),
    .thr_flag_clr_i          (thr_flag_clr_i),
    .ovr_flag_clr_i          (ovr_flag_clr_i),
    .cfg_rdata_o             (cfg_rdata_o),
    .ground_switch_pin_o     (ground_switch_pin_o),
    .current_accumulator_o   (current_accumulator_o),
    .threshold_count_value_o (threshold_count_value_o),
    .result_count_value_o    (result_count_value_o),
    .thr_flag_o              (thr_flag_o),
    .ovr_flag_o              (ovr_flag_o),
    .cur_irq_o               (cur_irq_o),
    .vt_last_o               (vt_last_o)
  );
  always #4 ref_clk_i = ~ref_clk_i;
  // drive one random cycle and note what the ports show after it
  task automatic step(input int n);
    logic [7:0]  cm;
    logic [15:0] d, mag, th;
    logic        neg, ge, set;
    @(negedge ref_clk_i);
    if (n % 256 == 0) begin
      current_threshold_i = 16'($urandom);
      threshold_count_limit_i = 8'(1 + $urandom % 3);
      result_count_limit_i = 16'(1 + $urandom % 3);
    end
    cur_res_i = {$urandom % 4 != 0, 16'($urandom)};
    vt_res_i = {$urandom % 4 == 0, 16'($urandom)};
    bipolar_i = 1'($urandom);
    cfg_wr_i = $urandom % 32 == 0;
    cfg_wdata_i = 8'($urandom) & 8'hfd;
    // keep the accumulator off until two results were taken while off
    if (cfg_m[6:5] != 2'b00) off_res = 0;
    else if (cur_res_i.valid) off_res++;
    if (cfg_m[6:5] == 2'b00 && off_res < 2)
      cfg_wdata_i[6:5] = 2'b00;
    mode_wr_i = $urandom % 32 == 0;
    thr_flag_clr_i = $urandom % 16 == 0;
    ovr_flag_clr_i = thr_flag_clr_i;
    ovr_raw_i = $urandom % 32 != 0; // no low power mode here
    cm = cfg_m;
    d = cur_res_i.data;
    if (cfg_wr_i) cfg_m = cfg_wdata_i;
    neg = bipolar_i & d[15];
    mag = neg ? -d : d;
    th = bipolar_i ? {1'b0, current_threshold_i[14:0]}
                   : current_threshold_i;
    ge = mag >= th;
    set = cur_res_i.valid && cm[4:3] == 2'b01 && ge;
    irq_m = 1'b0;
    if (cm[6:5] == 2'b00) acc_m = 32'h0;
    else if (cur_res_i.valid && cm[6:5] != 2'b11) begin
      if (!neg) acc_m = acc_m + mag;
      else if (cm[6:5] == 2'b01 && acc_m < mag) acc_m = 32'h0;
      else acc_m = acc_m - mag;
    end
    if (cur_res_i.valid && cm[4]) begin
      if (ge) thv_m = thv_m + 8'(thv_m != 8'hff);
      else if (!cm[3]) thv_m = 8'h00;
      else if (thv_m != 8'h00) thv_m = thv_m - 8'h01;
      set = thv_m == threshold_count_limit_i;
    end
    thr_m = set | (thr_m & !thr_flag_clr_i);
    if (mode_wr_i) rcv_m = 16'h0;
    else if (cur_res_i.valid && !cm[0]) irq_m = 1'b1;
    else if (cur_res_i.valid) begin
      rcv_m = rcv_m + 16'h1;
      if (rcv_m == result_count_limit_i) begin
        rcv_m = 16'h0;
        irq_m = 1'b1;
      end
    end
    run_m = (cm[2] && ovr_raw_i) ? run_m + 1 : 0;
    ovr_m = (run_m > OVR_CYCLES) | (ovr_m & !ovr_flag_clr_i);
    if (vt_res_i.valid) vt_m = vt_res_i.data;
    q.push_back({cfg_m, cfg_m[7], acc_m, thv_m, rcv_m, thr_m, ovr_m,
                 irq_m, vt_m});
  endtask
  // print the verdict and stop
  task automatic summarize();
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // compare the ports with the oldest note just after each edge
  always @(posedge ref_clk_i) begin
    if (q.size() != 0) begin
      #1;
      got = {cfg_rdata_o, ground_switch_pin_o, current_accumulator_o,
             threshold_count_value_o, result_count_value_o, thr_flag_o,
             ovr_flag_o, cur_irq_o, vt_last_o};
      want = q.pop_front();
      checks_done++;
      if (got !== want) begin
        num_errors++;
        $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
    end
  end
  // reset, random traffic, drain the notes
  initial begin
    {arst_n_i, cfg_wr_i, mode_wr_i, bipolar_i, ovr_raw_i} = 5'h00;
    {thr_flag_clr_i, ovr_flag_clr_i, cfg_wdata_i} = 10'h000;
    {current_threshold_i, result_count_limit_i} = 32'h0;
    threshold_count_limit_i = 8'h00;
    cur_res_i = '0;
    vt_res_i = '0;
    void'($urandom(75));
    repeat (2) @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    for (int n = 0; n < 6000; n++) step(n);
    for (int k = 0; k < 4 && q.size() != 0; k++) @(posedge ref_clk_i);
    #2;
    if (q.size() != 0) num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
